/* bsc_params.svh */
// Purpose: constants of the boundary-scan test port
// Assumes: included by the package and the boundary-scan module
// Notes: instruction codes are three bits wide
`ifndef BSC_PARAMS_SVH
`define BSC_PARAMS_SVH

// ----------------------------------------------------------------------
// chain geometry
// ----------------------------------------------------------------------
`define BSC_NUM_IO 4
`define BSC_CELLS_PER_IO 3
`define BSC_CHAIN_LEN (`BSC_NUM_IO * `BSC_CELLS_PER_IO)
`define BSC_CELL_IN 0
`define BSC_CELL_OUT 1
`define BSC_CELL_CTL 2

// ----------------------------------------------------------------------
// instruction register
// ----------------------------------------------------------------------
`define BSC_IR_LEN 3
`define BSC_IR_EXTEST 3'h0
`define BSC_IR_SAMPLE 3'h1
`define BSC_IR_HIGHZ 3'h5
`define BSC_IR_CLAMP 3'h6
`define BSC_IR_BYPASS 3'h7
`define BSC_IR_CAPTURE 3'h1
`define BSC_IR_RESET `BSC_IR_BYPASS

`endif

/* bsc_pkg.sv */
// Purpose: types shared by the boundary-scan test port
// Assumes: bsc_params.svh sits in the same folder
// Notes: state codes follow the usual tap encoding
package bsc_pkg;
`include "bsc_params.svh"

  // --------------------------------------------------------------------
  // tap controller states
  // --------------------------------------------------------------------
  typedef enum logic [3:0] {
    tap_exit2_dr = 4'h0,
    tap_exit1_dr = 4'h1,
    tap_shift_dr = 4'h2,
    tap_pause_dr = 4'h3,
    tap_sel_ir = 4'h4,
    tap_upd_dr = 4'h5,
    tap_cap_dr = 4'h6,
    tap_sel_dr = 4'h7,
    tap_exit2_ir = 4'h8,
    tap_exit1_ir = 4'h9,
    tap_shift_ir = 4'hA,
    tap_pause_ir = 4'hB,
    tap_idle = 4'hC,
    tap_upd_ir = 4'hD,
    tap_cap_ir = 4'hE,
    tap_reset = 4'hF
  } bsc_tap_state_t;

  // --------------------------------------------------------------------
  // pad drive: data and active-low output enable per i/o
  // --------------------------------------------------------------------
  typedef struct packed {
    logic [`BSC_NUM_IO-1:0] data;
    logic [`BSC_NUM_IO-1:0] oe_n;
  } bsc_pad_t;

endpackage : bsc_pkg

/* bsc_sync.sv */
// Purpose: two-flop level synchroniser
// Assumes: inputs are slow levels
// Notes: bits of a vector may settle one cycle apart
`timescale 1ns/1ps
module bsc_sync #(
  parameter int width = 1
) (
  input wire logic clk,
  input wire logic [width-1:0] d,
  output logic [width-1:0] q
);
  logic [width-1:0] meta;

  // --------------------------------------------------------------------
  // first flop feeds only the second
  // --------------------------------------------------------------------
  always_ff @(posedge clk) begin
    meta <= d;
    q <= meta;
  end
endmodule : bsc_sync

/* bsc_tap_fsm.sv */
// Purpose: sixteen-state tap controller
// Assumes: tck is the only clock, reset is synchronous
// Notes: five edges with tms high reach tap_reset from anywhere
`timescale 1ns/1ps
module bsc_tap_fsm (
  input wire logic tck,
  input wire logic rst,
  input wire logic en,
  input wire logic tms,
  output bsc_pkg::bsc_tap_state_t state
);
  import bsc_pkg::*;

  bsc_tap_state_t next_state;

  // --------------------------------------------------------------------
  // transitions
  // --------------------------------------------------------------------
  always_comb begin
    case (state)
      tap_reset: next_state = tms ? tap_reset : tap_idle;
      tap_idle: next_state = tms ? tap_sel_dr : tap_idle;
      tap_sel_dr: next_state = tms ? tap_sel_ir : tap_cap_dr;
      tap_cap_dr: next_state = tms ? tap_exit1_dr : tap_shift_dr;
      tap_shift_dr: next_state = tms ? tap_exit1_dr : tap_shift_dr;
      tap_exit1_dr: next_state = tms ? tap_upd_dr : tap_pause_dr;
      tap_pause_dr: next_state = tms ? tap_exit2_dr : tap_pause_dr;
      tap_exit2_dr: next_state = tms ? tap_upd_dr : tap_shift_dr;
      tap_upd_dr: next_state = tms ? tap_sel_dr : tap_idle;
      tap_sel_ir: next_state = tms ? tap_reset : tap_cap_ir;
      tap_cap_ir: next_state = tms ? tap_exit1_ir : tap_shift_ir;
      tap_shift_ir: next_state = tms ? tap_exit1_ir : tap_shift_ir;
      tap_exit1_ir: next_state = tms ? tap_upd_ir : tap_pause_ir;
      tap_pause_ir: next_state = tms ? tap_exit2_ir : tap_pause_ir;
      tap_exit2_ir: next_state = tms ? tap_upd_ir : tap_shift_ir;
      tap_upd_ir: next_state = tms ? tap_sel_dr : tap_idle;
      default: next_state = tap_reset;
    endcase
  end

  // tms sampled on the rising edge only
  always_ff @(posedge tck) begin
    if (rst) begin
      state <= tap_reset;
    end else if (en) begin
      state <= next_state;
    end
  end
endmodule : bsc_tap_fsm

/* bsc_boundary_scan.sv */
// Purpose: boundary-scan test port with chain and instruction decode
// Assumes: tck asynchronous to mclk and far slower
// Notes: pins and core sit on mclk, scan logic on tck
`timescale 1ns/1ps
`include "bsc_params.svh"

// Notes on behaviour
// - every i/o owns three scan cells with serial and parallel ports.
// - all cells form one chain from the data input to the data output.
// - cell parallel ports observe and steer i/o buffers and core logic.
// - test mode select is sampled on each rising test clock edge.
// - instruction and data bits are taken on each rising test clock edge.
// - the data output changes on the falling test clock edge.
// - the data output floats unless an instruction or data shift runs.
// - a 3-bit instruction is decoded, code 000 being external test.
// - code 001 snapshots pins without disturbing normal operation.
// - code 101 releases every i/o to high impedance.
// - code 110 drives the pins from the boundary register contents.
// - code 111 puts the one-bit bypass register between input and output.
module bsc_boundary_scan (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe_n,
  input wire bsc_pkg::bsc_pad_t core_drive,
  output logic [`BSC_NUM_IO-1:0] core_in,
  input wire logic [`BSC_NUM_IO-1:0] pad_in,
  output bsc_pkg::bsc_pad_t pad_drive
);
  import bsc_pkg::*;

  localparam int chain_len = `BSC_CHAIN_LEN;
  localparam int ir_len = `BSC_IR_LEN;
  localparam int num_io = `BSC_NUM_IO;

  // --------------------------------------------------------------------
  // test clock domain: reset and enable crossing
  // --------------------------------------------------------------------
  logic [1:0] ctl_t;
  logic rst_t;
  logic en_t;

  bsc_sync #(.width(2)) u_sync_ctl (
    .clk(tck),
    .d({sys_rst, clk_en}),
    .q(ctl_t)
  );
  assign rst_t = ctl_t[1];
  assign en_t = ctl_t[0];

  bsc_tap_state_t state;

  bsc_tap_fsm u_fsm (
    .tck(tck),
    .rst(rst_t),
    .en(en_t),
    .tms(tms),
    .state(state)
  );

  // --------------------------------------------------------------------
  // instruction and data registers
  // --------------------------------------------------------------------
  logic [ir_len-1:0] ir;
  logic [ir_len-1:0] ir_sh;
  logic [chain_len-1:0] bsr_sh;
  logic [chain_len-1:0] bsr_upd;
  logic [chain_len-1:0] snap_t;
  logic byp;
  logic [ir_len-1:0] next_ir;
  logic [ir_len-1:0] next_ir_sh;
  logic [chain_len-1:0] next_bsr_sh;
  logic [chain_len-1:0] next_bsr_upd;
  logic next_byp;
  logic sel_bsr;
  logic shifting;

  // anything but extest or sample routes through bypass
  assign sel_bsr = (ir == `BSC_IR_EXTEST) || (ir == `BSC_IR_SAMPLE);
  assign shifting = (state == tap_shift_dr) || (state == tap_shift_ir);

  always_comb begin
    next_ir = ir;
    next_ir_sh = ir_sh;
    next_bsr_sh = bsr_sh;
    next_bsr_upd = bsr_upd;
    next_byp = byp;
    case (state)
      tap_reset: next_ir = `BSC_IR_RESET;
      tap_cap_ir: next_ir_sh = `BSC_IR_CAPTURE;
      tap_shift_ir: next_ir_sh = {tdi, ir_sh[ir_len-1:1]};
      tap_upd_ir: next_ir = ir_sh;
      tap_cap_dr: begin
        if (sel_bsr) begin
          next_bsr_sh = snap_t;
        end else begin
          next_byp = 1'h0;
        end
      end
      tap_shift_dr: begin
        if (sel_bsr) begin
          next_bsr_sh = {tdi, bsr_sh[chain_len-1:1]};
        end else begin
          next_byp = tdi;
        end
      end
      tap_upd_dr: begin
        // clamp and highz leave the preloaded pattern untouched
        if (sel_bsr) begin
          next_bsr_upd = bsr_sh;
        end
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge tck) begin
    if (rst_t) begin
      ir <= `BSC_IR_RESET;
      ir_sh <= '0;
      bsr_sh <= '0;
      bsr_upd <= '0;
      byp <= 1'h0;
    end else if (en_t) begin
      ir <= next_ir;
      ir_sh <= next_ir_sh;
      bsr_sh <= next_bsr_sh;
      bsr_upd <= next_bsr_upd;
      byp <= next_byp;
    end
  end

  // --------------------------------------------------------------------
  // serial output on the falling edge
  // --------------------------------------------------------------------
  logic next_tdo;
  logic next_tdo_oe_n;

  always_comb begin
    if (state == tap_shift_ir) begin
      next_tdo = ir_sh[0];
    end else if (sel_bsr) begin
      next_tdo = bsr_sh[0];
    end else begin
      next_tdo = byp;
    end
    next_tdo_oe_n = !shifting;
  end

  // half a cycle after capture keeps hold time at the next device
  always_ff @(negedge tck) begin
    if (rst_t) begin
      tdo <= 1'h0;
      tdo_oe_n <= 1'h1;
    end else if (en_t) begin
      tdo <= next_tdo;
      tdo_oe_n <= next_tdo_oe_n;
    end
  end

  // --------------------------------------------------------------------
  // crossings between the domains
  // --------------------------------------------------------------------
  logic [chain_len+ir_len-1:0] up_m;
  logic [chain_len+ir_len-1:0] up_prev;
  logic [chain_len+ir_len-1:0] up_hold;
  logic [chain_len+ir_len-1:0] next_up_hold;
  logic [chain_len-1:0] upd_m;
  logic [ir_len-1:0] ir_m;
  logic [num_io-1:0] pad_in_m;
  logic [chain_len-1:0] snap;

  // update cells and instruction are quasi-static while in use
  bsc_sync #(.width(chain_len + ir_len)) u_sync_up (
    .clk(mclk),
    .d({ir, bsr_upd}),
    .q(up_m)
  );
  // bits settle apart; a word is used once two edges agree on it
  always_comb begin
    next_up_hold = up_hold;
    if (up_m == up_prev) begin
      next_up_hold = up_m;
    end
  end
  assign ir_m = up_hold[chain_len+ir_len-1:chain_len];
  assign upd_m = up_hold[chain_len-1:0];

  bsc_sync #(.width(num_io)) u_sync_pad (
    .clk(mclk),
    .d(pad_in),
    .q(pad_in_m)
  );

  // snapshot is sampled, not a coherent word; fine for static pins
  bsc_sync #(.width(chain_len)) u_sync_snap (
    .clk(tck),
    .d(snap),
    .q(snap_t)
  );

  // --------------------------------------------------------------------
  // pin side: three cells per i/o
  // --------------------------------------------------------------------
  logic m_highz;
  logic m_drive;
  logic m_extest;
  wire [chain_len-1:0] next_snap;
  wire [num_io-1:0] upd_out;
  wire [num_io-1:0] upd_ctl;
  wire [num_io-1:0] upd_in;
  wire [num_io-1:0] next_data;
  wire [num_io-1:0] next_oe_n;
  wire [num_io-1:0] next_core_in;

  assign m_highz = (ir_m == `BSC_IR_HIGHZ);
  assign m_extest = (ir_m == `BSC_IR_EXTEST);
  assign m_drive = m_extest || (ir_m == `BSC_IR_CLAMP);

  for (genvar i = 0; i < num_io; i++) begin : g_io
    localparam int base = i * `BSC_CELLS_PER_IO;
    // capture side of the three cells
    assign next_snap[base+`BSC_CELL_IN] = pad_in_m[i];
    assign next_snap[base+`BSC_CELL_OUT] = core_drive.data[i];
    assign next_snap[base+`BSC_CELL_CTL] = core_drive.oe_n[i];
    assign upd_in[i] = upd_m[base+`BSC_CELL_IN];
    assign upd_out[i] = upd_m[base+`BSC_CELL_OUT];
    assign upd_ctl[i] = upd_m[base+`BSC_CELL_CTL];
    assign next_data[i] = m_highz ? 1'h0 :
      (m_drive ? upd_out[i] : core_drive.data[i]);
    assign next_oe_n[i] = m_highz ? 1'h1 :
      (m_drive ? upd_ctl[i] : core_drive.oe_n[i]);
    assign next_core_in[i] = m_extest ? upd_in[i] : pad_in_m[i];
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pad_drive <= '{data: '0, oe_n: '1};
      core_in <= '0;
      snap <= '0;
      up_prev <= '0;
      up_hold <= {`BSC_IR_RESET, {chain_len{1'b0}}};
    end else if (clk_en) begin
      pad_drive <= '{data: next_data, oe_n: next_oe_n};
      core_in <= next_core_in;
      snap <= next_snap;
      up_prev <= up_m;
      up_hold <= next_up_hold;
    end
  end

  // --------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------
  sequence s_tms_high5;
    (en_t && tms) [*5];
  endsequence

  sequence s_ir_commit;
    en_t && state == tap_upd_ir;
  endsequence

  a_tap_reset_tms: assert property (
    @(posedge tck) disable iff (rst_t)
    s_tms_high5 |=> state == tap_reset)
    else $error("tap did not reach reset after five tms highs");

  a_ir_load: assert property (
    @(posedge tck) disable iff (rst_t)
    s_ir_commit |=> ir == $past(ir_sh))
    else $error("instruction not loaded on update");

  a_bsr_shift: assert property (
    @(posedge tck) disable iff (rst_t)
    en_t && state == tap_shift_dr && sel_bsr |=>
      bsr_sh == {$past(tdi), $past(bsr_sh[chain_len-1:1])})
    else $error("boundary chain did not shift from tdi");

  a_bsr_capture: assert property (
    @(posedge tck) disable iff (rst_t)
    en_t && state == tap_cap_dr && sel_bsr |=> bsr_sh == $past(snap_t))
    else $error("boundary chain did not capture pin snapshot");

  a_bypass_path: assert property (
    @(posedge tck) disable iff (rst_t)
    en_t && state == tap_shift_dr && !sel_bsr ##1 en_t && shifting
      |-> !tdo_oe_n && tdo == $past(tdi))
    else $error("bypass bit did not reach tdo");

  a_tdo_shift_out: assert property (
    @(posedge tck) disable iff (rst_t)
    en_t && state == tap_shift_dr && sel_bsr |->
      !tdo_oe_n && tdo == bsr_sh[0])
    else $error("tdo does not follow chain end");

  a_tdo_float: assert property (
    @(posedge tck) disable iff (rst_t)
    en_t && !shifting |-> tdo_oe_n)
    else $error("tdo driven outside a shift");

  a_highz_pins: assert property (
    @(posedge mclk) disable iff (sys_rst)
    clk_en && m_highz |=> pad_drive.oe_n == '1)
    else $error("pins not released in highz");

  a_clamp_drive: assert property (
    @(posedge mclk) disable iff (sys_rst)
    clk_en && m_drive && !m_highz |=>
      pad_drive.data == $past(upd_out) && pad_drive.oe_n == $past(upd_ctl))
    else $error("pins not driven from boundary register");

  a_sample_pass: assert property (
    @(posedge mclk) disable iff (sys_rst)
    clk_en && !m_drive && !m_highz |=> pad_drive == $past(core_drive))
    else $error("normal path disturbed outside test drive");

endmodule : bsc_boundary_scan

/* bsc_tester.sv */
// Purpose: behavioural test controller on the far side of the scan link
// Assumes: device moves tdo on the falling tck edge
// Notes: tck stands still between frames; tdo sampled before rising edge
`timescale 1ns/1ps
module bsc_tester (
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo,
  input wire logic tdo_oe_n
);
  logic last;

  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
    last = 1'b0;
  end

  // ------------------------------------------------------------------
  // one tck cycle, 64 ns so well inside the rate limit
  // ------------------------------------------------------------------
  task automatic step(input logic m, input logic d, output logic q,
                      output logic oe_n);
    tms = m;
    tdi = d;
    #32;
    // a released line shows no stale value
    q = (tdo_oe_n === 1'b0) ? tdo : ~last;
    oe_n = tdo_oe_n;
    last = q;
    tck = 1'b1;
    #32;
    tck = 1'b0;
  endtask : step

  // ------------------------------------------------------------------
  // frames
  // ------------------------------------------------------------------
  task automatic park(input int n);
    logic q;
    logic oe;
    #3;
    repeat (n) step(1'b1, 1'b0, q, oe);
    step(1'b0, 1'b0, q, oe);
  endtask : park

  // from idle: scan n bits lsb first, back to idle
  task automatic scan(input bit ir, input int n, input logic [15:0] din,
                      output logic [15:0] dout, output logic oe_bad);
    logic q;
    logic oe;
    dout = 16'h0000;
    #3;
    step(1'b1, 1'b0, q, oe);
    oe_bad = ~oe;
    if (ir) step(1'b1, 1'b0, q, oe);
    step(1'b0, 1'b0, q, oe);
    step(1'b0, 1'b0, q, oe);
    for (int k = 0; k < n; k++) begin
      step(k == n - 1, din[k], q, oe);
      dout[k] = q;
      oe_bad = oe_bad | oe;
    end
    step(1'b1, 1'b0, q, oe);
    oe_bad = oe_bad | ~oe;
    step(1'b0, 1'b0, q, oe);
  endtask : scan
endmodule : bsc_tester

/* tb_top.sv */
// Purpose: self-checking bench of the boundary-scan test port
// Assumes: bsc_tester stands in for the external test controller
// Notes: every tester frame after the first starts just after an mclk edge
`timescale 1ns/1ps
module tb_top;
  import bsc_pkg::*;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic clk_en = 1'b1;
  logic tck;
  logic tms;
  logic tdi;
  logic tdo;
  logic tdo_oe_n;
  bsc_pad_t core_drive = 8'h00;
  logic [3:0] core_in;
  logic [3:0] pad_in = 4'h0;
  bsc_pad_t pad_drive;
  int n_errors = 0;
  int n_compared = 0;
  int cycles = 0;

  bsc_boundary_scan i_dut (.mclk(mclk), .sys_rst(sys_rst), .clk_en(clk_en),
    .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe_n(tdo_oe_n),
    .core_drive(core_drive), .core_in(core_in), .pad_in(pad_in),
    .pad_drive(pad_drive));
  bsc_tester i_tester (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
    .tdo_oe_n(tdo_oe_n));

  always #4 mclk = ~mclk;

  // ------------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------------
  task automatic results();
    $display("checks %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : results

  // a run this short never needs more than a few thousand cycles
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      n_errors++;
      results();
    end
  end

  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wait_m(input int n);
    repeat (n) @(posedge mclk);
  endtask : wait_m

  // chain image: input, output data, output enable cells per i/o
  function automatic logic [15:0] cells(input logic [3:0] a, b, c);
    logic [15:0] v;
    v = 16'h0000;
    for (int i = 0; i < 4; i++) begin
      v[3*i] = a[i];
      v[3*i+1] = b[i];
      v[3*i+2] = c[i];
    end
    return v;
  endfunction : cells

  task automatic drive(input bsc_pad_t c, input logic [3:0] p);
    @(posedge mclk);
    core_drive <= c;
    pad_in <= p;
  endtask : drive

  task automatic dr(input int n, input logic [15:0] din,
                    output logic [15:0] dout);
    logic bad;
    wait_m(1);
    i_tester.scan(1'b0, n, din, dout, bad);
    check("dr tdo enable", {15'h0000, bad}, 16'h0000);
    wait_m(12);
  endtask : dr

  // mode crossing to mclk needs a few cycles after the update
  task automatic load_ir(input logic [2:0] code);
    logic [15:0] d;
    logic bad;
    wait_m(1);
    i_tester.scan(1'b1, 3, {13'h0000, code}, d, bad);
    check("ir capture", d, 16'h0001);
    check("ir tdo enable", {15'h0000, bad}, 16'h0000);
    wait_m(12);
  endtask : load_ir

  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  task automatic t_reset();
    i_tester.park(5);
    check("reset pads", {8'h00, pad_drive}, 16'h000F);
    check("reset tdo enable", {15'h0000, tdo_oe_n}, 16'h0001);
    @(posedge mclk);
    sys_rst <= 1'b0;
    drive({4'hA, 4'h5}, 4'hC);
    wait_m(1);
    i_tester.park(6);
    wait_m(8);
    check("normal pads", {8'h00, pad_drive}, 16'h00A5);
    check("normal core", {12'h000, core_in}, 16'h000C);
  endtask : t_reset

  task automatic t_bypass();
    logic [2:0] codes [4] = '{3'h7, 3'h2, 3'h3, 3'h4};
    logic [15:0] d;
    foreach (codes[i]) begin
      load_ir(codes[i]);
      dr(5, 16'h0016, d);
      check("bypass tdo", d, 16'h000C);
    end
  endtask : t_bypass

  task automatic t_sample();
    logic [15:0] d;
    drive({4'h9, 4'h6}, 4'h5);
    load_ir(3'h1);
    dr(12, cells(4'h3, 4'hA, 4'hC), d);
    check("sample chain", d, cells(4'h5, 4'h9, 4'h6));
    check("sample pads", {8'h00, pad_drive}, 16'h0096);
    check("sample core", {12'h000, core_in}, 16'h0005);
  endtask : t_sample

  task automatic t_extest();
    logic [15:0] d;
    drive({4'h9, 4'h6}, 4'hA);
    load_ir(3'h0);
    check("extest pads", {8'h00, pad_drive}, 16'h00AC);
    check("extest core", {12'h000, core_in}, 16'h0003);
    dr(12, cells(4'hC, 4'h5, 4'h0), d);
    check("extest chain", d, cells(4'hA, 4'h9, 4'h6));
    check("extest update", {8'h00, pad_drive}, 16'h0050);
    check("extest core upd", {12'h000, core_in}, 16'h000C);
  endtask : t_extest

  task automatic t_modes();
    load_ir(3'h6);
    check("clamp pads", {8'h00, pad_drive}, 16'h0050);
    check("clamp core", {12'h000, core_in}, 16'h000A);
    load_ir(3'h5);
    check("highz pads", {8'h00, pad_drive}, 16'h000F);
    load_ir(3'h7);
    check("bypass pads", {8'h00, pad_drive}, 16'h0096);
  endtask : t_modes

  // pin side holds while the enable is low, then catches up
  task automatic t_freeze();
    drive({4'h3, 4'hC}, 4'h6);
    clk_en <= 1'b0;
    wait_m(6);
    check("frozen pads", {8'h00, pad_drive}, 16'h0096);
    check("frozen core", {12'h000, core_in}, 16'h000A);
    clk_en <= 1'b1;
    wait_m(6);
    check("thawed pads", {8'h00, pad_drive}, 16'h003C);
    check("thawed core", {12'h000, core_in}, 16'h0006);
  endtask : t_freeze

  initial begin
    t_reset();
    t_bypass();
    t_sample();
    t_extest();
    t_modes();
    t_freeze();
    results();
  end
endmodule : tb_top
